// ### verilog/rsse_consts.vh
`ifndef RSSE_CONSTS_VH
`define RSSE_CONSTS_VH
// ----------------------------------------
// opcode fields
// ----------------------------------------
`define RSSE_OP_RRC      6'h0c
`define RSSE_OP_RRN      6'h10
`define RSSE_OP_FILL     7'h34
`define RSSE_OP_HALT     16'h0003
`define RSSE_D_BIT       9
`define RSSE_A_BIT       8
// ----------------------------------------
// constants
// ----------------------------------------
`define RSSE_ONES        8'hff
`define RSSE_ZERO8       8'h00
`define RSSE_ACC_RST     8'h00
`define RSSE_BANK_RST    4'h0
`define RSSE_IND_ADDR    8'hef
`define RSSE_ACC_HI_BASE 8'h80
`define RSSE_ACC_HI_BANK 4'hf
`define RSSE_PTR_RST     12'h000
`endif

// ### verilog/rsse_rotator.v
`timescale 1ns/10ps
`default_nettype none
module rsse_rotator (
	input  wire [7:0] operand_in,
	input  wire       carry_in,
	input  wire       through_carry_in,
	output wire [7:0] result_out,
	output wire       carry_out
);
	// ----------------------------------------
	// right rotate datapath
	// ----------------------------------------
	assign result_out = {through_carry_in ? carry_in : operand_in[0], operand_in[7:1]};
	assign carry_out  = through_carry_in ? operand_in[0] : carry_in;
endmodule // rsse_rotator
`default_nettype wire

// ### verilog/rsse_exec.v
`timescale 1ns/10ps
`include "rsse_consts.vh"
`default_nettype none
module rsse_exec (
	input  wire        core_clk_in,
	input  wire        sys_rst_in,
	input  wire        instr_valid_in,
	input  wire [15:0] instr_word_in,
	input  wire [3:0]  bank_select_reg_in,
	input  wire [11:0] indirect_pointer_zero_in,
	input  wire [7:0]  mem_rdata_in,
	output reg  [11:0] mem_addr_out,
	output reg         mem_rd_out,
	output reg         mem_wr_out,
	output reg  [7:0]  mem_wdata_out,
	output reg  [7:0]  working_accumulator_out,
	output reg         carry_out,
	output reg         zero_out,
	output reg         negative_out,
	output reg         expiry_flag_out,
	output reg         powerdown_flag_out,
	output reg         watchdog_clear_out,
	output reg         osc_stop_out,
	output reg         sleeping_out,
	output reg         busy_out
);
	// ----------------------------------------
	// phases, one-hot
	// ----------------------------------------
	localparam [4:0] PH_IDLE = 5'h01;
	localparam [4:0] PH_DEC  = 5'h02;
	localparam [4:0] PH_READ = 5'h04;
	localparam [4:0] PH_PROC = 5'h08;
	localparam [4:0] PH_WRT  = 5'h10;

	reg  [4:0]  phase_q;
	reg  [15:0] ir_q;
	reg  [7:0]  opnd_q;
	reg  [7:0]  res_q;
	reg         cres_q;
	wire [7:0]  rot_res;
	wire        rot_c;
	wire        is_rrc  = ir_q[15:10] == `RSSE_OP_RRC;
	wire        is_rrn  = ir_q[15:10] == `RSSE_OP_RRN;
	wire        is_fill = ir_q[15:9] == `RSSE_OP_FILL;
	wire        is_halt = ir_q == `RSSE_OP_HALT;
	wire        is_rot  = is_rrc | is_rrn;
	wire        dest_f  = ir_q[`RSSE_D_BIT];
	wire        acc_a   = ir_q[`RSSE_A_BIT];
	reg  [11:0] addr_d;

	rsse_rotator u_rot (
		.operand_in       (opnd_q),
		.carry_in         (carry_out),
		.through_carry_in (is_rrc),
		.result_out       (rot_res),
		.carry_out        (rot_c)
	);

	// ----------------------------------------
	// address formation
	// ----------------------------------------
	always @* begin
		if (ir_q[7:0] == `RSSE_IND_ADDR)
			addr_d = indirect_pointer_zero_in;
		else if (acc_a)
			addr_d = {bank_select_reg_in, ir_q[7:0]};
		else if (ir_q[7:0] >= `RSSE_ACC_HI_BASE)
			addr_d = {`RSSE_ACC_HI_BANK, ir_q[7:0]};
		else
			addr_d = {`RSSE_BANK_RST, ir_q[7:0]};
	end

	// ----------------------------------------
	// five-phase sequencer, next values
	// ----------------------------------------
	// one decision point per phase keeps the register block a plain copy
	reg  [4:0]  phase_d;
	reg  [15:0] ir_d;
	reg  [7:0]  opnd_d;
	reg  [7:0]  res_d;
	reg         cres_d;
	reg  [11:0] mem_addr_d;
	reg         mem_rd_d;
	reg         mem_wr_d;
	reg  [7:0]  mem_wdata_d;
	reg  [7:0]  acc_d;
	reg         carry_d;
	reg         zero_d;
	reg         negative_d;
	reg         expiry_d;
	reg         powerdown_d;
	reg         wdog_clr_d;
	reg         osc_stop_d;
	reg         sleeping_d;
	reg         busy_d;

	// pointer is only read, never written, so indirect access leaves it intact
	always @* begin
		phase_d     = phase_q;
		ir_d        = ir_q;
		opnd_d      = opnd_q;
		res_d       = res_q;
		cres_d      = cres_q;
		mem_addr_d  = mem_addr_out;
		mem_rd_d    = 1'b0;
		mem_wr_d    = 1'b0;
		mem_wdata_d = mem_wdata_out;
		acc_d       = working_accumulator_out;
		carry_d     = carry_out;
		zero_d      = zero_out;
		negative_d  = negative_out;
		expiry_d    = expiry_flag_out;
		powerdown_d = powerdown_flag_out;
		wdog_clr_d  = 1'b0;
		osc_stop_d  = osc_stop_out;
		sleeping_d  = sleeping_out;
		busy_d      = busy_out;
		case (phase_q)
		PH_IDLE: begin
			// sleep holds until reset; wake logic lives elsewhere
			if (instr_valid_in && !sleeping_out) begin
				ir_d    = instr_word_in;
				phase_d = PH_DEC;
				busy_d  = 1'b1;
			end
		end
		PH_DEC: begin
			mem_addr_d = addr_d;
			mem_rd_d   = is_rot;
			phase_d    = PH_READ;
		end
		PH_READ: begin
			opnd_d  = mem_rdata_in;
			phase_d = PH_PROC;
		end
		PH_PROC: begin
			res_d   = is_fill ? `RSSE_ONES : rot_res;
			cres_d  = rot_c;
			phase_d = PH_WRT;
		end
		PH_WRT: begin
			phase_d = PH_IDLE;
			busy_d  = 1'b0;
			if (is_fill) begin
				mem_wr_d    = 1'b1;
				mem_wdata_d = res_q;
			end else if (is_rot) begin
				if (dest_f) begin
					mem_wr_d    = 1'b1;
					mem_wdata_d = res_q;
				end else begin
					acc_d = res_q;
				end
				carry_d    = cres_q;
				zero_d     = res_q == `RSSE_ZERO8;
				negative_d = res_q[7];
			end else if (is_halt) begin
				wdog_clr_d  = 1'b1;
				expiry_d    = 1'b1;
				powerdown_d = 1'b0;
				osc_stop_d  = 1'b1;
				sleeping_d  = 1'b1;
			end
		end
		default: phase_d = PH_IDLE;
		endcase
	end

	// ----------------------------------------
	// five-phase sequencer, registers
	// ----------------------------------------
	// every output is a flop, so the memory side sees no decode glitches
	always @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			phase_q                 <= PH_IDLE;
			ir_q                    <= 16'h0000;
			opnd_q                  <= `RSSE_ZERO8;
			res_q                   <= `RSSE_ZERO8;
			cres_q                  <= 1'b0;
			mem_addr_out            <= `RSSE_PTR_RST;
			mem_rd_out              <= 1'b0;
			mem_wr_out              <= 1'b0;
			mem_wdata_out           <= `RSSE_ZERO8;
			working_accumulator_out <= `RSSE_ACC_RST;
			carry_out               <= 1'b0;
			zero_out                <= 1'b0;
			negative_out            <= 1'b0;
			expiry_flag_out         <= 1'b1;
			powerdown_flag_out      <= 1'b1;
			watchdog_clear_out      <= 1'b0;
			osc_stop_out            <= 1'b0;
			sleeping_out            <= 1'b0;
			busy_out                <= 1'b0;
		end else begin
			phase_q                 <= phase_d;
			ir_q                    <= ir_d;
			opnd_q                  <= opnd_d;
			res_q                   <= res_d;
			cres_q                  <= cres_d;
			mem_addr_out            <= mem_addr_d;
			mem_rd_out              <= mem_rd_d;
			mem_wr_out              <= mem_wr_d;
			mem_wdata_out           <= mem_wdata_d;
			working_accumulator_out <= acc_d;
			carry_out               <= carry_d;
			zero_out                <= zero_d;
			negative_out            <= negative_d;
			expiry_flag_out         <= expiry_d;
			powerdown_flag_out      <= powerdown_d;
			watchdog_clear_out      <= wdog_clr_d;
			osc_stop_out            <= osc_stop_d;
			sleeping_out            <= sleeping_d;
			busy_out                <= busy_d;
		end
	end
endmodule // rsse_exec
`default_nettype wire

// ### testbench/rsse_exec_sva.sv
`timescale 1ns/10ps
`default_nettype none
module rsse_exec_sva (
	input wire logic        core_clk_in,
	input wire logic        sys_rst_in,
	input wire logic        instr_valid_in,
	input wire logic [15:0] instr_word_in,
	input wire logic        busy_out,
	input wire logic        sleeping_out,
	input wire logic        mem_rd_out,
	input wire logic        mem_wr_out,
	input wire logic [7:0]  mem_wdata_out,
	input wire logic        carry_out,
	input wire logic        expiry_flag_out,
	input wire logic        powerdown_flag_out,
	input wire logic        watchdog_clear_out,
	input wire logic        osc_stop_out
);
	// ----------------------------------------
	// request decode
	// ----------------------------------------
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	wire       tk   = instr_valid_in && !busy_out && !sleeping_out;
	wire [5:0] op   = instr_word_in[15:10];
	wire       rot  = op == 6'h0c || op == 6'h10;
	wire       fill = instr_word_in[15:9] == 7'h34;
	wire       halt = instr_word_in == 16'h0003;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_take_busy: assert property (tk |=> busy_out)
		else $error("no busy");
	a_busy_ends: assert property (busy_out |-> ##[1:6] !busy_out)
		else $error("busy stuck");
	a_wr_pulse: assert property (mem_wr_out |=> !mem_wr_out)
		else $error("long write");
	a_rot_read: assert property (tk && rot |-> ##2 mem_rd_out)
		else $error("no operand read");
	a_fill_ones: assert property (tk && fill |->
		##[1:6] mem_wr_out && mem_wdata_out == 8'hff) else $error("fill bad");
	a_rrn_carry: assert property (tk && op == 6'h10 |=> $stable(carry_out)[*6])
		else $error("carry moved");
	a_acc_dest: assert property (tk && rot && !instr_word_in[9] |=> !mem_wr_out[*6])
		else $error("file written");
	a_file_dest: assert property (tk && rot && instr_word_in[9] |-> ##[1:6] mem_wr_out)
		else $error("no write");
	a_halt_flags: assert property (tk && halt |-> ##[1:6]
		expiry_flag_out && !powerdown_flag_out && osc_stop_out && sleeping_out)
		else $error("halt bad");
	a_wdog_clear: assert property (tk && halt |-> ##5 watchdog_clear_out)
		else $error("no watchdog clear");
	a_sleep_held: assert property (sleeping_out |=> sleeping_out)
		else $error("woke");
endmodule // rsse_exec_sva
bind rsse_exec rsse_exec_sva chk(.*);
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
logic clk = 0, rst = 1, iv = 0, mc = 0, mz = 0, mn = 0;
logic [15:0] w = 0;
logic [3:0] bank_select_reg = 0;
logic [11:0] ptr = 0;
logic [7:0] rd = 0, macc = 0;
logic [31:0] s = 32'h0433, fr;
logic [32:0] q[$], got = 0;
logic [2:0] bs = 0;
wire [11:0] ma;
wire [7:0] wd, acc;
wire wr, c, z, n, sl, bz;
int n_errors = 0, n_compared = 0, cyc = 0;
always #10 clk = !clk;
rsse_exec uut(.core_clk_in(clk), .sys_rst_in(rst), .instr_valid_in(iv), .instr_word_in(w),
	.bank_select_reg_in(bank_select_reg), .indirect_pointer_zero_in(ptr), .mem_rdata_in(rd),
	.mem_addr_out(ma), .mem_rd_out(), .mem_wr_out(wr), .mem_wdata_out(wd),
	.working_accumulator_out(acc), .carry_out(c), .zero_out(z), .negative_out(n),
	.expiry_flag_out(), .powerdown_flag_out(), .watchdog_clear_out(), .osc_stop_out(),
	.sleeping_out(sl), .busy_out(bz));
function logic [31:0] rnd();
	s ^= s << 13; s ^= s >> 17; s ^= s << 5; return s;
endfunction
task chk(input [32:0] g, e);
	n_compared++;
	if (g !== e) begin n_errors++; $display("[FAIL] result exp %h got %h", e, g); end
endtask
task test_done;
	$display("compared %0d errors %0d", n_compared, n_errors);
	if (n_errors == 0 && n_compared > 0) $display("All checks passed");
	else $display("Checks failed");
	$finish;
endtask
// outputs change on the edge busy drops, but bs needs two more edges to show it, so compare late
always @(posedge clk) begin
	cyc <= cyc + 1;
	bs <= {bs[1:0], bz};
	if (wr) got[20:0] <= {1'b1, wd, ma};
	if (bs == 3'b100) begin
		chk({sl, acc, c, z, n, got[20:0]}, q.pop_front());
		got <= 0;
	end
	// ceiling well above 34 instructions of about ten cycles each
	if (cyc == 2000) begin
		n_errors++;
		test_done;
	end
end
task op(input [15:0] iw, input [7:0] m);
	logic [31:0] t; logic [7:0] v, r; logic [11:0] ad; logic nc; logic [32:0] e;
	t = rnd(); v = t[23:16] & m;
	bank_select_reg <= t[3:0]; ptr <= t[15:4]; rd <= v; w <= iw; iv <= 1;
	ad = iw[7:0] == 8'hef ? t[15:4] : iw[8] ? {t[3:0], iw[7:0]} : {iw[7] ? 4'hf : 4'h0, iw[7:0]};
	r = iw[14] ? {v[0], v[7:1]} : {mc, v[7:1]};
	nc = iw[14] ? mc : v[0];
	e = {1'b0, macc, mc, mz, mn, 21'h0};
	if (iw[15:9] == 7'h34) e[20:0] = {1'b1, 8'hff, ad};
	else if (iw[15:10] == 6'h0c || iw[15:10] == 6'h10) begin
		mc = nc; mz = r == 8'h00; mn = r[7];
		if (iw[9]) e = {1'b0, macc, mc, mz, mn, 1'b1, r, ad};
		else begin macc = r; e = {1'b0, r, mc, mz, mn, 21'h0}; end
	end else if (iw == 16'h0003) e[32] = 1'b1;
	q.push_back(e);
	@(posedge clk); iv <= 0;
	while (q.size() > 0) @(posedge clk);
endtask
initial begin
	repeat (3) @(posedge clk); rst <= 0;
	for (int i = 0; i < 32; i++) begin
		fr = rnd();
		op({i[1:0] == 0 ? 6'h0c : i[1:0] == 1 ? 6'h10 : i[1:0] == 2 ? 6'h1a : 6'h3f,
			i[2] & (i[1:0] != 2), i[3], i[4] ? 8'hef : fr[7:0]}, i[4:2] == 7 ? 8'h01 : 8'hff);
	end
	$display("rotate fill test done");
	op(16'h0003, 8'hff); $display("halt test done");
	rst <= 1; repeat (3) @(posedge clk); rst <= 0;
	macc = 0; mc = 0; mz = 0; mn = 0;
	op(16'h33ef, 8'hff); $display("reset test done");
	test_done;
end
endmodule // tb
`default_nettype wire
